// >>> hw/fdp_pkg.sv
// Constants for the discovery parameter store: register map, bytes and layout
`default_nettype none
package fdp_pkg;
  // Wishbone word offsets (byte addresses)
  localparam logic [7:0] ADDR_WIN_LO = 8'h00;  // Parameter bytes 00h..03h
  localparam logic [7:0] ADDR_WIN_HI = 8'h2C;  // Last window word, bytes 2Ch..2Fh
  localparam logic [7:0] ADDR_CTRL = 8'h40;    // Byte pointer for streamed reads
  localparam logic [7:0] ADDR_DATA = 8'h44;    // Byte at pointer, pointer advances
  localparam logic [7:0] ADDR_INFO = 8'h48;    // Model and pointer state
  // Parameter header
  localparam logic [7:0] PARAM_ID = 8'hA5;      // Discovery parameter identifier
  localparam logic [7:0] PARAM_LEN = 8'h80;     // Bytes following the length byte
  localparam logic [7:0] HDR_BYTES = 8'h02;     // Header bytes ahead of table data
  localparam logic [15:0] TABLE_BASE = 16'h1090; // Discovery-space address of table
  // First dword fields
  localparam logic [2:0] D1_UNUSED_HI = 3'b111;   // Bits 7:5
  localparam logic [1:0] D1_SR_WRITE = 2'b00;     // Bits 4:3, 06h writes non-volatile SR
  localparam logic D1_BUF_GT64 = 1'b1;            // Bit 2
  localparam logic [1:0] D1_ERASE4K = 2'b11;      // Bits 1:0, unavailable
  localparam logic [7:0] D1_ERASE_OP = 8'hFF;     // Bits 15:8
  localparam logic D1_UNUSED_23 = 1'b1;           // Bit 23
  localparam logic D1_QUAD_OUT = 1'b0;            // Bit 22
  localparam logic D1_QUAD_IO = 1'b1;             // Bit 21
  localparam logic D1_DUAL_IO = 1'b1;             // Bit 20
  localparam logic [1:0] D1_ADDR_BYTES = 2'b01;   // Bits 18:17, 3 or 4 bytes
  localparam logic D1_DUAL_OUT = 1'b0;            // Bit 16
  localparam logic [7:0] D1_UNUSED_TOP = 8'hFF;   // Bits 31:24
  // Second dword: density in bits minus one, 1 Gb
  localparam logic [31:0] DENSITY_M1 = 32'h3FFF_FFFF;
  // Bytes beyond the covered range read erased
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] LAST_OFS = 8'h81;      // Last byte of the parameter
  // Enabled edges after reset before the strap has crossed both sync stages
  localparam logic [1:0] CAPTURE_EDGE = 2'h2;
endpackage
`default_nettype wire

// >>> hw/fdp_rom.sv
// Discovery parameter store with a classic Wishbone read port
//
// Added by the designer: the register addresses and the Wishbone slave port.
`default_nettype none
module fdp_rom (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Model strap: high on the DDR-capable variant
  input wire logic ddr_model_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o
);

  // Strap synchroniser; only the second stage is read
  logic ddr_s1_reg;
  logic ddr_s2_reg;
  // Latched model, caught after reset release so the table stays stable
  logic ddr_reg;
  logic ddr_caught_reg;
  // Counts enabled edges after reset until the second stage holds the strap
  logic [1:0] cap_cnt_reg;
  // Byte pointer for streamed reads
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  // Bus answer registers
  logic [31:0] dat_reg;
  logic ack_reg;
  logic err_reg;

  // Byte lookup by parameter-relative offset
  function automatic logic [7:0] param_byte(input logic [7:0] ofs, input logic ddr);
    logic [31:0] dw1;
    dw1 = {fdp_pkg::D1_UNUSED_TOP,
           fdp_pkg::D1_UNUSED_23, fdp_pkg::D1_QUAD_OUT, fdp_pkg::D1_QUAD_IO,
           fdp_pkg::D1_DUAL_IO, ddr, fdp_pkg::D1_ADDR_BYTES, fdp_pkg::D1_DUAL_OUT,
           fdp_pkg::D1_ERASE_OP,
           fdp_pkg::D1_UNUSED_HI, fdp_pkg::D1_SR_WRITE,
           fdp_pkg::D1_BUF_GT64, fdp_pkg::D1_ERASE4K};
    case (ofs)
      8'h00: param_byte = fdp_pkg::PARAM_ID;
      8'h01: param_byte = fdp_pkg::PARAM_LEN;
      // Table bytes start at header end; low byte first
      8'h02: param_byte = dw1[7:0];
      8'h03: param_byte = dw1[15:8];
      8'h04: param_byte = dw1[23:16];
      8'h05: param_byte = dw1[31:24];
      8'h06: param_byte = fdp_pkg::DENSITY_M1[7:0];
      8'h07: param_byte = fdp_pkg::DENSITY_M1[15:8];
      8'h08: param_byte = fdp_pkg::DENSITY_M1[23:16];
      8'h09: param_byte = fdp_pkg::DENSITY_M1[31:24];
      // Later dwords are outside this block; they read erased
      default: param_byte = fdp_pkg::BLANK_BYTE;
    endcase
  endfunction

  // Address decode
  wire logic req = cyc_i && stb_i && !ack_reg && !err_reg;
  wire logic hit_win = (adr_i[1:0] == 2'b00) && (adr_i <= fdp_pkg::ADDR_WIN_HI);
  wire logic hit_ctrl = (adr_i == fdp_pkg::ADDR_CTRL);
  wire logic hit_data = (adr_i == fdp_pkg::ADDR_DATA);
  wire logic hit_info = (adr_i == fdp_pkg::ADDR_INFO);
  // Window is read-only; a write there is refused with err
  wire logic mapped = (hit_win && !we_i) || hit_ctrl || (hit_data && !we_i) || hit_info && !we_i;
  // One word of four consecutive bytes, lowest offset in bits 7:0
  wire logic [7:0] wb0 = param_byte(adr_i, ddr_reg);
  wire logic [7:0] wb1 = param_byte(adr_i + 8'h01, ddr_reg);
  wire logic [7:0] wb2 = param_byte(adr_i + 8'h02, ddr_reg);
  wire logic [7:0] wb3 = param_byte(adr_i + 8'h03, ddr_reg);
  wire logic [7:0] stream_byte = param_byte(ptr_reg, ddr_reg);
  // Pointer value offered by a control write
  wire logic [7:0] load_byte = dat_i[7:0];
  wire logic [31:0] info_word = {16'h0000, ptr_reg, 7'h00, ddr_reg};
  wire logic [31:0] rd_word = hit_win ? {wb3, wb2, wb1, wb0} :
                              hit_ctrl ? {24'h00_0000, ptr_reg} :
                              hit_data ? {24'h00_0000, stream_byte} :
                              info_word;

  // Pointer: set by write, advances on each data read, wraps after the last byte
  always_comb begin
    ptr_next = ptr_reg;
    if (req && hit_ctrl && we_i && sel_i[0]) begin
      ptr_next = load_byte;
    end else if (req && hit_data && !we_i) begin
      ptr_next = (ptr_reg >= fdp_pkg::LAST_OFS) ? 8'h00 : ptr_reg + 8'h01;
    end
  end

  // Strap sync and one-time capture after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ddr_s1_reg <= 1'b0;
      ddr_s2_reg <= 1'b0;
      ddr_reg <= 1'b0;
      ddr_caught_reg <= 1'b0;
      cap_cnt_reg <= 2'h0;
    end else if (ce_i) begin
      ddr_s1_reg <= ddr_model_i;
      ddr_s2_reg <= ddr_s1_reg;
      if (cap_cnt_reg != fdp_pkg::CAPTURE_EDGE) begin
        // Second stage still shows its reset value, not the strap
        cap_cnt_reg <= cap_cnt_reg + 2'h1;
      end else if (!ddr_caught_reg) begin
        ddr_reg <= ddr_s2_reg;
        ddr_caught_reg <= 1'b1;
      end
    end
  end

  // Bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= 8'h00;
      dat_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (ce_i) begin
      ptr_reg <= ptr_next;
      ack_reg <= req && mapped;
      err_reg <= req && !mapped;
      if (req && mapped && !we_i) begin
        dat_reg <= rd_word;
      end
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign err_o = err_reg;

  // Checks
  // Table bytes are fixed apart from the strap bit, so these catch a bad package edit at once
  // Identifier byte of the parameter
  a_id_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    param_byte(8'h00, ddr_reg) == 8'hA5)
    else $error("id byte wrong");
  // Length byte counts what follows it
  a_len_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    param_byte(8'h01, ddr_reg) == 8'h80)
    else $error("length byte wrong");
  // First table byte: unused bits, status write, buffer and erase fields
  a_first_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    param_byte(8'h02, ddr_reg) == 8'hE7)
    else $error("first table byte wrong");
  // No uniform small-sector erase opcode
  a_erase_op: assert property (@(posedge clk_i) disable iff (rst_i)
    param_byte(8'h03, ddr_reg) == 8'hFF)
    else $error("erase opcode byte wrong");
  // Read modes and address bytes, strap bit masked out
  a_read_modes: assert property (@(posedge clk_i) disable iff (rst_i)
    (param_byte(8'h04, ddr_reg) & 8'hF7) == 8'hB2)
    else $error("read mode bits wrong");
  // Double-data-rate bit follows the latched strap
  a_ddr_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (param_byte(8'h04, ddr_reg) & 8'h08) == {4'h0, ddr_reg, 3'h0})
    else $error("ddr bit wrong");
  // Top byte of the first dword is unused
  a_top_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    param_byte(8'h05, ddr_reg) == 8'hFF)
    else $error("top byte wrong");
  // Density in bits minus one, low byte first
  a_density_word: assert property (@(posedge clk_i) disable iff (rst_i)
    {param_byte(8'h09, ddr_reg), param_byte(8'h08, ddr_reg),
     param_byte(8'h07, ddr_reg), param_byte(8'h06, ddr_reg)} == 32'h3FFF_FFFF)
    else $error("density wrong");

  // Request shapes, as sampled on the edge where the store takes them
  // Window read of the header word
  sequence s_win_read;
    req && hit_win && !we_i && (adr_i == 8'h00);
  endsequence
  // Window read of the upper half of the first dword
  sequence s_win_read_04;
    req && hit_win && !we_i && (adr_i == 8'h04);
  endsequence
  // Window read across the density dword
  sequence s_win_read_08;
    req && hit_win && !we_i && (adr_i == 8'h08);
  endsequence
  // Window read of the last word, past the covered bytes
  sequence s_win_read_2c;
    req && hit_win && !we_i && (adr_i == fdp_pkg::ADDR_WIN_HI);
  endsequence
  // Streamed read with the pointer on the identifier byte
  sequence s_data_at_id;
    req && hit_data && !we_i && (ptr_reg == 8'h00);
  endsequence
  // Streamed read with the pointer on the last byte of the parameter
  sequence s_data_at_last;
    req && hit_data && !we_i && (ptr_reg == fdp_pkg::LAST_OFS);
  endsequence
  // Streamed read anywhere before the last byte
  sequence s_data_step;
    req && hit_data && !we_i && (ptr_reg < fdp_pkg::LAST_OFS);
  endsequence
  // Pointer load from the bus
  sequence s_ptr_load;
    req && hit_ctrl && we_i && sel_i[0];
  endsequence
  // Read of the model and pointer word
  sequence s_info_read;
    req && hit_info && !we_i;
  endsequence
  // Any write into the read-only space
  sequence s_bad_write;
    req && we_i && (hit_win || hit_data || hit_info);
  endsequence
  // Request to an address that decodes to nothing, unaligned window words included
  sequence s_unmapped;
    req && !hit_win && !hit_ctrl && !hit_data && !hit_info;
  endsequence
  // Answer shapes, one cycle after the request
  // Clean acknowledge
  sequence s_ack_only;
    ack_o && !err_o;
  endsequence
  // Refusal
  sequence s_err_only;
    err_o && !ack_o;
  endsequence

  // Bus answers; a frozen enable delays them, so those cycles are left out
  // Header word: identifier in bits 7:0, then length, then the first table byte
  a_win_order: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_win_read |=> s_ack_only ##0 (dat_o == 32'hFFE7_80A5))
    else $error("window word order wrong");
  // Upper half of the first dword: read modes, strap bit, unused top byte
  a_win_dword1: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_win_read_04 |=> s_ack_only ##0 (dat_o[31:8] == 24'hFF_FFFF) ##0
      ((dat_o[7:0] & 8'hF7) == 8'hB2) ##0 (dat_o[3] == $past(ddr_reg)))
    else $error("first dword upper half wrong");
  // Density high bytes land in the low half of this word
  a_win_density: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_win_read_08 |=> s_ack_only ##0 (dat_o == 32'hFFFF_3FFF))
    else $error("density word wrong");
  // Later tables are not held here, so the tail reads erased
  a_win_tail: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_win_read_2c |=> s_ack_only ##0 (dat_o == 32'hFFFF_FFFF))
    else $error("window tail not erased");
  // Streamed view starts with the identifier
  a_stream_id: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_data_at_id |=> s_ack_only ##0 (dat_o == 32'h0000_00A5))
    else $error("stream start wrong");
  // Last byte reads erased and the pointer wraps to the identifier
  a_stream_wrap: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_data_at_last |=> s_ack_only ##0 (dat_o == 32'h0000_00FF) ##0 (ptr_reg == 8'h00))
    else $error("stream wrap wrong");
  // Bytes follow one another with no gap
  a_ptr_step: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_data_step |=> s_ack_only ##0 (ptr_reg == $past(ptr_reg) + 8'h01))
    else $error("pointer step wrong");
  // Control write loads the pointer
  a_ptr_load: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_ptr_load |=> s_ack_only ##0 (ptr_reg == $past(load_byte)))
    else $error("pointer load wrong");
  // Model word shows the pointer and the latched strap
  a_info_word: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_info_read |=> s_ack_only ##0
      (dat_o == {16'h0000, $past(ptr_reg), 7'h00, $past(ddr_reg)}))
    else $error("info word wrong");
  // Window, data and info words are read-only: writes there are refused
  a_bad_write: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_bad_write |=> s_err_only)
    else $error("write not refused");
  // Holes in the map are refused
  a_unmapped: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    s_unmapped |=> s_err_only)
    else $error("unmapped access not refused");
  // Acknowledge lasts one cycle
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && ce_i |=> !ack_o)
    else $error("ack held too long");
  // Refusal lasts one cycle
  a_err_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o && ce_i |=> !err_o)
    else $error("err held too long");
  // Never both answers at once
  a_one_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o))
    else $error("ack and err together");
  // Enable low freezes answers, read data and pointer
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(ack_o) && $stable(err_o) && $stable(dat_o) && $stable(ptr_reg))
    else $error("state moved while frozen");
  // Strap is latched from the second sync stage once it is valid
  a_strap_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ddr_caught_reg && (cap_cnt_reg == fdp_pkg::CAPTURE_EDGE) |=>
      ddr_caught_reg && (ddr_reg == $past(ddr_s2_reg)))
    else $error("strap capture wrong");
  // Table stays stable until the next reset
  a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ddr_caught_reg |=> $stable(ddr_reg))
    else $error("strap changed after capture");
endmodule
`default_nettype wire

// >>> bench/fdp_host.sv
// Host controller model: classic Wishbone master for the parameter store
`default_nettype none
module fdp_host (
  // Clock
  input wire logic clk_i,
  // Request to the store
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  // Answer from the store
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  input wire logic err_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // Byte enables for the next cycle; a scenario may clear them to test ignored writes
  logic [3:0] sel_v = 4'hF;
  // One classic cycle; only the bench watchdog ends a wait on a dead slave
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, sel_v, d};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1 && err_i !== 1'b1);
    q = dat_i;
    e = err_i;
    // Released data shows the inverse so stale values cannot pass
    {cyc_o, stb_o, we_o, dat_o} <= {3'b000, ~d};
  endtask
endmodule
`default_nettype wire

// >>> bench/fdp_rom_bench.sv
// Self-checking bench for the discovery parameter store
`default_nettype none
module fdp_rom_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, ddr_i = 1'b0; // Bench-driven inputs
  logic cyc, stb, we, ack, err; // Bus wires
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd, q;
  logic e;
  int bad_count = 0, checked = 0, seed = 24163, p;
  fdp_rom fdp_rom_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ddr_model_i(ddr_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
    .dat_o(rd), .ack_o(ack), .err_o(err));
  fdp_host fdp_host_inst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wd), .dat_i(rd), .ack_i(ack), .err_i(err));
  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Expected parameter byte at offset o for strap d
  function automatic logic [7:0] eb(input int o, input logic d);
    case (o)
      0: return 8'hA5;
      1: return 8'h80;
      2: return 8'hE7;
      4: return {4'hB, d, 3'b010};
      9: return 8'h3F;
      default: return 8'hFF;
    endcase
  endfunction
  // Word at byte address a, lowest offset in bits 7:0
  function automatic logic [31:0] ew(input int a, input logic d);
    return {eb(a + 3, d), eb(a + 2, d), eb(a + 1, d), eb(a, d)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    fdp_host_inst.xfer(1'b0, a, 32'h0, q, e);
    chk({q[31:1], q[0] ^ e}, exp);
  endtask
  // Twelve-cycle reset, then let the strap settle
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude();
  end
  initial begin
    ddr_i <= 1'($random(seed));
    do_reset();
    for (int a = 0; a < 48; a += 4) rd_chk(8'(a), ew(a, ddr_i));
    $display("window test done");
    // Enable held low while a request stands: the answer must wait for it
    fork
      rd_chk(8'h08, ew(8, ddr_i));
      begin
        ce_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    $display("freeze test done");
    for (int k = 0; k < 2; k++) begin
      p = k ? $unsigned($random(seed)) % 130 : 126;
      fdp_host_inst.xfer(1'b1, 8'h40, 32'(p), q, e);
      chk({31'h0, e}, 32'h0);
      for (int i = 0; i < 6; i++) rd_chk(8'h44, {24'h0, eb((p + i) % 130, ddr_i)});
      rd_chk(8'h40, 32'((p + 6) % 130));
    end
    $display("stream test done");
    fdp_host_inst.xfer(1'b1, 8'h00, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    fdp_host_inst.xfer(1'b0, 8'h80, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    fdp_host_inst.xfer(1'b0, 8'h01, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    rd_chk(8'h00, ew(0, ddr_i));
    rd_chk(8'h48, {16'h0, 8'((p + 6) % 130), 7'h0, ddr_i});
    // Pointer write with its byte lane disabled is acknowledged but ignored
    fdp_host_inst.sel_v = 4'h0;
    fdp_host_inst.xfer(1'b1, 8'h40, 32'h5, q, e);
    fdp_host_inst.sel_v = 4'hF;
    chk({31'h0, e}, 32'h0);
    rd_chk(8'h40, 32'((p + 6) % 130));
    $display("refusal test done");
    ddr_i <= ~ddr_i;
    do_reset();
    rd_chk(8'h04, ew(4, ddr_i));
    $display("strap test done");
    conclude();
  end
endmodule
`default_nettype wire
